/* File: hdl/lcc_regs.sv */
/*
 * Laser channel current register bank with speckle-reduction alternation.
 * Holds gain, offset, timing and negative offset words for three channels
 * behind an APB slave and drives each channel's gain and present current.
 * Assumes APB inputs come from logic on CLK_SYS; alternation steps on
 * CLK_SYS, which stands for the device's fast alternation clock.
 * Limitations: only byte lane 0 is stored, so PSTRB[0] low makes a write a
 * silent no-op. Gain and offset words change one byte at a time, so the
 * drive outputs briefly show a mix of old and new bytes; software that
 * cares writes the high register last or parks the channel first.
 * Phase codes are re-read every cycle: lowering one in mid-phase ends the
 * phase early rather than letting its count wrap.
 */
`timescale 1ns/1ns

module lcc_regs
    import lcc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock, reset and enable
    input  wire logic                              CLK_SYS,
    input  wire logic                              RST_N,
    input  wire logic                              CLK_EN,
    // APB slave
    input  wire logic                              PSEL,
    input  wire logic                              PENABLE,
    input  wire logic                              PWRITE,
    input  wire logic [ADDR_W-1:0]                 PADDR,
    input  wire logic [31:0]                       PWDATA,
    input  wire logic [3:0]                        PSTRB,
    output logic      [31:0]                       PRDATA,
    output logic                                   PREADY,
    output logic                                   PSLVERR,
    // Channel drive, index 0 to 2 is channel zero to two
    output logic      [NUM_CHAN-1:0][WORD_W-1:0]   CHAN_GAIN,
    output logic      [NUM_CHAN-1:0][WORD_W-1:0]   CHAN_CURRENT,
    output logic      [NUM_CHAN-1:0]               CHAN_OFF_PHASE
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_REGS-1:0][7:0]             regs;
        lcc_phase_t [NUM_CHAN-1:0]            phase;
        logic [NUM_CHAN-1:0][TIME_W-1:0]      cnt;
        logic [NUM_CHAN-1:0][WORD_W-1:0]      gain;
        logic [NUM_CHAN-1:0][WORD_W-1:0]      current;
        logic [NUM_CHAN-1:0]                  off_phase;
        logic [31:0]                          prdata;
        logic                                 pready;
        logic                                 pslverr;
    } lcc_state_t;

    lcc_state_t  st_r;
    lcc_state_t  st_nxt;
    logic        rst_meta_r;
    logic        rst_sync_n_r;

    // ------------------------------------------------------------------
    // Register map (index; the byte address is four times it)
    // ------------------------------------------------------------------
    // 0x11        channel two high: gain bits [7:4], offset bits [3:0]
    // 0x12, 0x13  channel two gain low, offset low
    // 0x14        channel one high
    // 0x15, 0x16  channel one gain low, offset low
    // 0x17        channel zero high
    // 0x18, 0x19  channel zero gain low, offset low
    // 0x1A        speckle mode: [7:6] two, [5:4] one, [3:2] zero, [1:0] reserved
    // 0x1B..0x1D  phase timing for two, one, zero: [7:4] on code, [3:0] off code
    // 0x1E..0x23  negative offset high nibble and low byte, two down to zero
    // Every register resets to zero. Nothing outside this range is decoded,
    // so a stray access reports an error instead of aliasing onto a live
    // register.

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------

    // Array slot of a register index; only meaningful inside the bank, and
    // every caller either passes a fixed index or is gated by req_hit
    function automatic logic [4:0] slot(input logic [7:0] idx);
        logic [7:0] d;
        d    = idx - IDX_FIRST;
        slot = d[4:0];
    endfunction

    // Writable bits; reserved bits stay zero so they read back as zero
    // Keeping them zero in storage means no read path needs its own mask
    function automatic logic [7:0] wmask(input logic [7:0] idx);
        logic [7:0] m;
        m = FULL_MASK;
        if (idx == IDX_SPECKLE_CTRL) begin
            m = CTRL_MASK;
        end
        if (idx == IDX_CHAN2_NEG_HIGH || idx == IDX_CHAN1_NEG_HIGH ||
            idx == IDX_CHAN0_NEG_HIGH) begin
            m = NEG_HIGH_MASK;
        end
        wmask = m;
    endfunction

    // Twelve-bit word from a high nibble and a low byte
    function automatic logic [WORD_W-1:0] word12(input logic [3:0] hi, input logic [7:0] lo);
        word12 = {hi, lo};
    endfunction

    // Per-channel register indices; channels are laid out from two down to zero
    // The same decoding is needed for every channel, hence functions over c
    function automatic logic [7:0] high_idx(input int c);
        case (c)
            0:       high_idx = IDX_CHAN0_HIGH;
            1:       high_idx = IDX_CHAN1_HIGH;
            default: high_idx = IDX_CHAN2_HIGH;
        endcase
    endfunction

    function automatic logic [7:0] gain_low_idx(input int c);
        case (c)
            0:       gain_low_idx = IDX_CHAN0_GAIN_LOW;
            1:       gain_low_idx = IDX_CHAN1_GAIN_LOW;
            default: gain_low_idx = IDX_CHAN2_GAIN_LOW;
        endcase
    endfunction

    function automatic logic [7:0] offset_low_idx(input int c);
        case (c)
            0:       offset_low_idx = IDX_CHAN0_OFFSET_LOW;
            1:       offset_low_idx = IDX_CHAN1_OFFSET_LOW;
            default: offset_low_idx = IDX_CHAN2_OFFSET_LOW;
        endcase
    endfunction

    function automatic logic [7:0] timing_idx(input int c);
        case (c)
            0:       timing_idx = IDX_CHAN0_TIMING;
            1:       timing_idx = IDX_CHAN1_TIMING;
            default: timing_idx = IDX_CHAN2_TIMING;
        endcase
    endfunction

    function automatic logic [7:0] neg_high_idx(input int c);
        case (c)
            0:       neg_high_idx = IDX_CHAN0_NEG_HIGH;
            1:       neg_high_idx = IDX_CHAN1_NEG_HIGH;
            default: neg_high_idx = IDX_CHAN2_NEG_HIGH;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Address decode of the current request
    // ------------------------------------------------------------------
    logic [7:0]  req_idx;
    logic        req_hit;
    logic        req_acc;

    // Word-aligned addresses inside the bank hit; anything else errors
    // The access flag covers both access cycles; the ready flop tells them apart
    assign req_idx = 8'(PADDR[ADDR_W-1:2]);
    assign req_hit = (PADDR[1:0] == 2'b00) && (req_idx >= IDX_FIRST) && (req_idx <= IDX_LAST);
    assign req_acc = PSEL && PENABLE;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0]        hi;
        logic [7:0]        tim;
        logic [WORD_W-1:0] offs;
        logic [WORD_W-1:0] neg;
        logic [3:0]        target;
        lcc_mode_t         mode;
        hi     = '0;
        tim    = '0;
        offs   = '0;
        neg    = '0;
        target = '0;
        mode   = SPK_OFF;
        st_nxt = st_r;

        // One wait state: ready rises in the second access cycle
        // PRDATA holds between transfers and reads zero after a write; only PREADY qualifies it
        if (req_acc && !st_r.pready) begin
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = !req_hit;
            st_nxt.prdata  = (req_hit && !PWRITE) ? {24'h000000, st_r.regs[slot(req_idx)]}
                                                  : 32'h00000000;
        end else begin
            st_nxt.pready  = 1'b0;
            st_nxt.pslverr = 1'b0;
        end

        // Write lands at the completing edge; lane 0 carries the byte
        // Refused and unstrobed writes fall through and leave the bank unchanged
        if (req_acc && st_r.pready && PWRITE && req_hit && PSTRB[0]) begin
            st_nxt.regs[slot(req_idx)] = PWDATA[7:0] & wmask(req_idx);
        end

        // Channel alternation and drive, from the freshly written registers
        // Reading st_nxt lets a byte written at the completing edge reach the
        // drive outputs at that same edge, one cycle sooner than st_r would
        for (int c = 0; c < NUM_CHAN; c++) begin
            hi   = st_nxt.regs[slot(high_idx(c))];
            tim  = st_nxt.regs[slot(timing_idx(c))];
            mode = lcc_mode_t'(st_nxt.regs[slot(IDX_SPECKLE_CTRL)]
                               [CTRL_MODE_LSB + CTRL_MODE_STEP*c +: 2]);
            st_nxt.gain[c] = word12(hi[HIGH_GAIN_LSB +: 4],
                                    st_nxt.regs[slot(gain_low_idx(c))]);
            offs = word12(hi[HIGH_OFFSET_LSB +: 4],
                          st_nxt.regs[slot(offset_low_idx(c))]);
            neg  = word12(st_nxt.regs[slot(neg_high_idx(c))][3:0],
                          st_nxt.regs[slot(neg_high_idx(c)) + 5'd1]);

            // Phase timer: code n holds the phase for n + 1 cycles
            // Greater-or-equal, not equal: a code lowered below the running count
            // ends the phase next cycle instead of wrapping past sixteen
            case (st_r.phase[c])
                PH_ON:   target = tim[TIME_ON_LSB +: TIME_W];
                PH_OFF:  target = tim[TIME_OFF_LSB +: TIME_W];
                default: target = '0;
            endcase
            // Mode 00 parks the channel in its on phase with a cleared count,
            // so enabling a mode later always starts from a known point
            if (mode == SPK_OFF) begin
                st_nxt.phase[c] = PH_ON;
                st_nxt.cnt[c]   = '0;
            end else if (st_r.cnt[c] >= target) begin
                st_nxt.cnt[c]   = '0;
                st_nxt.phase[c] = (st_r.phase[c] == PH_ON) ? PH_OFF : PH_ON;
            end else begin
                st_nxt.cnt[c]   = st_r.cnt[c] + 4'h1;
            end

            // Off-phase current per mode; the on phase always drives the offset
            // The offset is the resting current in every mode, alternating or not
            st_nxt.off_phase[c] = (st_nxt.phase[c] == PH_OFF);
            st_nxt.current[c]   = offs;
            if (st_nxt.phase[c] == PH_OFF) begin
                case (mode)
                    SPK_ZERO:     st_nxt.current[c] = '0;
                    SPK_OFFSET:   st_nxt.current[c] = offs;
                    // Clamp at zero so a large negative offset cannot wrap
                    SPK_NEGATIVE: st_nxt.current[c] = (neg > offs) ? '0
                                                      : offs - neg;
                    default:      st_nxt.current[c] = offs;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------

    // Release is synchronous so no flop sees a partial reset edge
    // RST_N is read nowhere else; all state uses the synchronised copy
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_r   <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r   <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Clock enable low freezes the whole bank, bus handshake included
    // A master that drops the enable in the wait cycle simply waits longer; a write completing while it is low is lost
    always_ff @(posedge CLK_SYS or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            st_r <= '{regs:    {NUM_REGS{REG_RESET}},
                      phase:   '{default: PH_ON},
                      default: '0};
        end else if (CLK_EN) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Plain copies of state registers, so no combinational path reaches a pin
    assign PRDATA         = st_r.prdata;
    assign PREADY         = st_r.pready;
    assign PSLVERR        = st_r.pslverr;
    assign CHAN_GAIN      = st_r.gain;
    assign CHAN_CURRENT   = st_r.current;
    assign CHAN_OFF_PHASE = st_r.off_phase;

endmodule

/* File: hdl/lcc_pkg.sv */
/*
 * Package for the laser channel current register bank: register indices,
 * field positions, reset values, speckle modes and alternation phases.
 * Assumes an APB register bus with 32-bit data; each register is one
 * aligned word at byte address four times its index.
 */
package lcc_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CHAN = 3;
    localparam int WORD_W   = 12;
    localparam int TIME_W   = 4;
    localparam int NUM_REGS = 19;

    // ------------------------------------------------------------------
    // Register indices (byte address = index * 4)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_FIRST             = 8'h11;
    localparam logic [7:0] IDX_LAST              = 8'h23;
    localparam logic [7:0] IDX_CHAN2_HIGH        = 8'h11;
    localparam logic [7:0] IDX_CHAN2_GAIN_LOW    = 8'h12;
    localparam logic [7:0] IDX_CHAN2_OFFSET_LOW  = 8'h13;
    localparam logic [7:0] IDX_CHAN1_HIGH        = 8'h14;
    localparam logic [7:0] IDX_CHAN1_GAIN_LOW    = 8'h15;
    localparam logic [7:0] IDX_CHAN1_OFFSET_LOW  = 8'h16;
    localparam logic [7:0] IDX_CHAN0_HIGH        = 8'h17;
    localparam logic [7:0] IDX_CHAN0_GAIN_LOW    = 8'h18;
    localparam logic [7:0] IDX_CHAN0_OFFSET_LOW  = 8'h19;
    localparam logic [7:0] IDX_SPECKLE_CTRL      = 8'h1A;
    localparam logic [7:0] IDX_CHAN2_TIMING      = 8'h1B;
    localparam logic [7:0] IDX_CHAN1_TIMING      = 8'h1C;
    localparam logic [7:0] IDX_CHAN0_TIMING      = 8'h1D;
    localparam logic [7:0] IDX_CHAN2_NEG_HIGH    = 8'h1E;
    localparam logic [7:0] IDX_CHAN2_NEG_LOW     = 8'h1F;
    localparam logic [7:0] IDX_CHAN1_NEG_HIGH    = 8'h20;
    localparam logic [7:0] IDX_CHAN1_NEG_LOW     = 8'h21;
    localparam logic [7:0] IDX_CHAN0_NEG_HIGH    = 8'h22;
    localparam logic [7:0] IDX_CHAN0_NEG_LOW     = 8'h23;

    // ------------------------------------------------------------------
    // Field positions, masks and reset value
    // ------------------------------------------------------------------
    localparam int         HIGH_GAIN_LSB   = 4;
    localparam int         HIGH_OFFSET_LSB = 0;
    localparam int         CTRL_MODE_LSB   = 2;
    localparam int         CTRL_MODE_STEP  = 2;
    localparam int         TIME_ON_LSB     = 4;
    localparam int         TIME_OFF_LSB    = 0;
    localparam logic [7:0] NEG_HIGH_MASK   = 8'h0F;
    localparam logic [7:0] CTRL_MASK       = 8'hFC;
    localparam logic [7:0] FULL_MASK       = 8'hFF;
    localparam logic [7:0] REG_RESET       = 8'h00;

    // ------------------------------------------------------------------
    // Speckle modes and alternation phases
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SPK_OFF      = 2'b00,
        SPK_ZERO     = 2'b01,
        SPK_OFFSET   = 2'b10,
        SPK_NEGATIVE = 2'b11
    } lcc_mode_t;

    typedef enum logic {
        PH_ON,
        PH_OFF
    } lcc_phase_t;

endpackage

/* File: verif/lcc_regs_assertions.sv */
/* Checker for lcc_regs: a shadow of the register image built from APB
   writes, and channel drive checks against it. Bound to lcc_regs and
   sees only its ports; assumes no APB traffic while CLK_EN is low. */
`timescale 1ns/1ns
module lcc_regs_assertions
    import lcc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock, reset and enable
    input wire logic                            CLK_SYS,
    input wire logic                            RST_N,
    input wire logic                            CLK_EN,
    // APB slave side
    input wire logic                            PSEL,
    input wire logic                            PENABLE,
    input wire logic                            PWRITE,
    input wire logic [ADDR_W-1:0]               PADDR,
    input wire logic [31:0]                     PWDATA,
    input wire logic [3:0]                      PSTRB,
    input wire logic                            PREADY,
    input wire logic                            PSLVERR,
    // Channel drive
    input wire logic [NUM_CHAN-1:0][WORD_W-1:0] CHAN_GAIN,
    input wire logic [NUM_CHAN-1:0][WORD_W-1:0] CHAN_CURRENT,
    input wire logic [NUM_CHAN-1:0]             CHAN_OFF_PHASE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic [7:0] shd_r [0:63];
    // ------------------------------------------------------------
    // Shadow image, indexed by register index
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            shd_r <= '{default: REG_RESET};
        end else if (PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PSTRB[0] && CLK_EN) begin
            shd_r[PADDR[7:2]] <= PWDATA[7:0];
        end
    end
    // Words per channel: high at 0x17-3c, negative offset at 0x22-2c
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_ch
        logic [WORD_W-1:0] gain_w, off_w, neg_w, low_w;
        logic [1:0]        mode_w;
        logic [4:0]        run_r;
        logic              ph;
        assign ph     = CHAN_OFF_PHASE[c];
        assign gain_w = {shd_r[23-3*c][7:4], shd_r[24-3*c]};
        assign off_w  = {shd_r[23-3*c][3:0], shd_r[25-3*c]};
        assign neg_w  = {shd_r[34-2*c][3:0], shd_r[35-2*c]};
        assign low_w  = (off_w > neg_w) ? off_w - neg_w : '0;
        assign mode_w = shd_r[26][2*c+2 +: 2];
        // Counts enabled cycles only, a frozen phase is not a long one
        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                run_r <= '0;
            end else if (CLK_EN) begin
                run_r <= ph ? run_r + 5'h1 : 5'h0;
            end
        end
        // Outputs follow a write at the same edge as the shadow, so no shift
        property p_gain; CHAN_GAIN[c] == gain_w; endproperty
        a_gain: assert property (p_gain) else $error("gain word mismatch");
        property p_on; !ph |-> CHAN_CURRENT[c] == off_w; endproperty
        a_on: assert property (p_on) else $error("on current mismatch");
        property p_quiet; mode_w == 2'b00 |-> !ph; endproperty
        a_quiet: assert property (p_quiet) else $error("steady channel left on phase");
        property p_zero; ph && mode_w == 2'b01 |-> CHAN_CURRENT[c] == '0; endproperty
        a_zero: assert property (p_zero) else $error("off current not zero");
        property p_offs; ph && mode_w == 2'b10 |-> CHAN_CURRENT[c] == off_w;
        endproperty
        a_offs: assert property (p_offs) else $error("off current not offset");
        property p_neg; ph && mode_w == 2'b11 |-> CHAN_CURRENT[c] == low_w;
        endproperty
        a_neg: assert property (p_neg) else $error("off current not reduced");
        property p_len; ph |-> run_r <= {1'b0, shd_r[29-c][3:0]}; endproperty
        a_len: assert property (p_len) else $error("off phase too long");
        // A fall caused by parking the channel is no phase end and is skipped
        property p_min; $fell(ph) && mode_w != 2'b00 |->
            run_r == {1'b0, shd_r[29-c][3:0]} + 5'h1;
        endproperty
        a_min: assert property (p_min) else $error("off phase too short");
    end
    // Main scenarios
    c_err: cover property (PREADY && PSLVERR);
    c_freeze: cover property (!CLK_EN && CHAN_OFF_PHASE != '0);
    c_alt: cover property ($fell(CHAN_OFF_PHASE[1]));
endmodule
bind lcc_regs lcc_regs_assertions #(.ADDR_W(ADDR_W)) i_lcc_regs_assertions (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CLK_EN(CLK_EN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CHAN_GAIN(CHAN_GAIN), .CHAN_CURRENT(CHAN_CURRENT),
    .CHAN_OFF_PHASE(CHAN_OFF_PHASE));

/* File: verif/laser_channel_current_regs_bench.sv */
/* Self-checking bench for lcc_regs: APB master tasks and one task per
   scenario. Assumes the checker is bound in and a 100 MHz clock. */
`timescale 1ns/1ns
module laser_channel_current_regs_bench
    import lcc_pkg::*;
;
    logic                            clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
    logic                            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]                      paddr = 8'h00, rd;
    logic [31:0]                     pwdata = 32'h0, prdata;
    logic [3:0]                      pstrb = 4'hF;
    logic                            pready, pslverr, err;
    logic [NUM_CHAN-1:0][WORD_W-1:0] gain, curr;
    logic [NUM_CHAN-1:0]             offph;
    int                              fails = 0, n_compared = 0, n;
    lcc_regs i_lcc_regs (.CLK_SYS(clk_sys), .RST_N(rst_n), .CLK_EN(clk_en), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CHAN_GAIN(gain),
        .CHAN_CURRENT(curr), .CHAN_OFF_PHASE(offph));
    // Free-running 10 ns clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [35:0] exp, input logic [35:0] got, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // One APB transfer; register index in, byte address is four times it
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [3:0] sb);
        int k;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx[5:0], 2'b00};
        pwdata  <= {24'h000000, wd};
        pstrb   <= sb;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            fails++;
            $display("[ERR] %0t bus answer timed out", $time);
            close_out();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd, 4'hF);
        chk(1'b0, err, "write error");
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00, 4'hF);
        chk(exp, rd, "read data");
    endtask
    // Waits for channel one's phase to read v; the count is the run before it
    task automatic skip(input logic v);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (offph[1] !== v && n < 40);
        if (offph[1] !== v) begin
            fails++;
            $display("[ERR] %0t phase wait timed out", $time);
            close_out();
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int i = 8'h15; i <= 8'h1A; i++) begin
            rdc(8'(i), REG_RESET);
        end
        chk('0, gain, "gain at reset");
        chk('0, offph, "phase at reset");
        apb(1'b0, 8'h30, 8'h00, 4'hF);
        chk(1'b1, err, "unmapped error");
        chk(8'h00, rd, "unmapped data");
        $display("test reset done");
    endtask
    task automatic t_words();
        wr(IDX_CHAN0_HIGH, 8'hAB);
        wr(IDX_CHAN0_GAIN_LOW, 8'hCD);
        wr(IDX_CHAN0_OFFSET_LOW, 8'hEF);
        wr(IDX_CHAN1_HIGH, 8'h12);
        wr(IDX_CHAN1_GAIN_LOW, 8'h34);
        wr(IDX_CHAN1_OFFSET_LOW, 8'h56);
        wr(IDX_CHAN2_HIGH, 8'h9A);
        wr(IDX_CHAN2_GAIN_LOW, 8'h78);
        wr(IDX_CHAN2_OFFSET_LOW, 8'h65);
        apb(1'b1, IDX_CHAN0_GAIN_LOW, 8'h00, 4'hE);
        chk(1'b0, err, "unstrobed write error");
        cyc(2);
        chk(12'hACD, gain[0], "chan0 gain");
        chk(12'hBEF, curr[0], "chan0 current");
        chk(12'h134, gain[1], "chan1 gain");
        chk(12'h256, curr[1], "chan1 current");
        chk(12'h978, gain[2], "chan2 gain");
        chk(12'hA65, curr[2], "chan2 current");
        rdc(IDX_CHAN0_HIGH, 8'hAB);
        wr(IDX_SPECKLE_CTRL, 8'h03);
        rdc(IDX_SPECKLE_CTRL, 8'h00);
        $display("test words done");
    endtask
    task automatic t_modes();
        logic [11:0] exp [1:3];
        logic [11:0] exp2 [1:3];
        int          offs;
        exp  = '{12'h000, 12'hBEF, 12'hAEF};
        exp2 = '{12'h000, 12'hA65, 12'hA00};
        wr(IDX_CHAN2_NEG_LOW, 8'h65);
        wr(IDX_CHAN0_NEG_HIGH, 8'h01);
        wr(IDX_CHAN0_NEG_LOW, 8'h00);
        wr(IDX_CHAN0_TIMING, 8'h00);
        for (int m = 1; m <= 3; m++) begin
            wr(IDX_SPECKLE_CTRL, 8'((m << 6) | (m << 2)));
            cyc(2);
            offs = 0;
            repeat (8) begin
                @(posedge clk_sys);
                offs += (offph[0] === 1'b1) ? 1 : 0;
                chk(offph[0] ? exp[m] : 12'hBEF, curr[0], "current");
                chk(1'b0, offph[1], "chan1 steady");
                chk(offph[2] ? exp2[m] : 12'hA65, curr[2], "chan2 current");
                chk(offph[0], offph[2], "chan2 in step");
            end
            chk(36'd4, 36'(offs), "off cycles");
        end
        wr(IDX_SPECKLE_CTRL, 8'h00);
        cyc(2);
        repeat (3) begin
            @(posedge clk_sys);
            chk(1'b0, offph[0], "mode off steady");
            chk(1'b0, offph[2], "chan2 off steady");
        end
        $display("test modes done");
    endtask
    task automatic t_timing();
        logic v;
        wr(IDX_CHAN1_TIMING, 8'h0F);
        wr(IDX_SPECKLE_CTRL, 8'h10);
        skip(1'b1);
        skip(1'b0);
        chk(36'd16, 36'(n), "off phase length");
        skip(1'b1);
        chk(36'd1, 36'(n), "on phase length");
        chk(1'b0, offph[0], "chan0 steady");
        // Freeze: a running phase would flip within one 17-cycle period
        clk_en <= 1'b0;
        cyc(1);
        v = offph[1];
        repeat (20) begin
            @(posedge clk_sys);
            chk(v, offph[1], "frozen phase");
        end
        clk_en <= 1'b1;
        wr(IDX_SPECKLE_CTRL, 8'h00);
        $display("test timing done");
    endtask
    // Main sequence: reset held six cycles, then the scenarios
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        cyc(4);
        t_reset();
        t_words();
        t_modes();
        t_timing();
        close_out();
    end
endmodule
